// ### cpl_pkg.sv
// Package for the charge port load detect and fault block.
// Assumes a 125 MHz system clock; analog events arrive as synchronous levels.
package cpl_pkg;
  localparam int unsigned CPL_CLK_HZ = 125000000;
  // Qualification and timing figures in their own units
  localparam int unsigned CPL_ASSERT_MS = 200;
  localparam int unsigned CPL_RELEASE_MS = 3000;
  localparam int unsigned CPL_FLT_DEGLITCH_US = 8;
  localparam int unsigned CPL_DISCHARGE_MS = 330;
  localparam int unsigned CPL_RETEST_MS = 200;
  localparam int unsigned CPL_ASSERT_CYC = CPL_CLK_HZ / 1000 * CPL_ASSERT_MS;
  localparam int unsigned CPL_RELEASE_CYC = CPL_CLK_HZ / 1000 * CPL_RELEASE_MS;
  localparam int unsigned CPL_FLT_DEGLITCH_CYC = CPL_CLK_HZ / 1000000 * CPL_FLT_DEGLITCH_US;
  localparam int unsigned CPL_DISCHARGE_CYC = CPL_CLK_HZ / 1000 * CPL_DISCHARGE_MS;
  localparam int unsigned CPL_RETEST_CYC = CPL_CLK_HZ / 1000 * CPL_RETEST_MS;
  localparam int unsigned CPL_CNT_W = 32;
  // Mode codes: {mode_pin_one, mode_pin_two, mode_pin_three, current_select_input}
  localparam logic [3:0] CPL_CODE_CDP = 4'hf;
  localparam logic [3:0] CPL_CODE_SECOND_STANDARD_MODE = 4'he;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] CPL_REG_CTRL = 8'h00;
  localparam logic [7:0] CPL_REG_STATUS = 8'h04;
  localparam logic [7:0] CPL_REG_MODE = 8'h08;
  // Control field positions and reset values
  localparam int unsigned CPL_CTRL_MODE_LSB = 0;
  localparam int unsigned CPL_CTRL_SW_EN = 4;
  localparam logic [31:0] CPL_CTRL_RST = 32'h00000000;

  typedef enum logic [2:0] {
    CPL_MODE_DISCHARGE,
    CPL_MODE_AUTO_DCP,
    CPL_MODE_FIRST_STANDARD_MODE,
    CPL_MODE_SECOND_STANDARD_MODE,
    CPL_MODE_CDP,
    CPL_MODE_FORCED_SHORTED,
    CPL_MODE_FORCED_FIRST_DIVIDER_SCHEME
  } cpl_mode_t;

  typedef enum logic [1:0] {
    CPL_SCH_FIRST_DIVIDER_SCHEME,
    CPL_SCH_SECOND_DIVIDER_SCHEME,
    CPL_SCH_SHORTED
  } cpl_scheme_t;

  // Decode of the four mode bits, used by the top only
  function automatic cpl_mode_t cpl_decode(input logic [3:0] code);
    cpl_mode_t m;
    m = CPL_MODE_DISCHARGE;
    case (code[3:1])
      3'h0: m = CPL_MODE_DISCHARGE;
      3'h1: m = CPL_MODE_AUTO_DCP;
      3'h2: m = CPL_MODE_FIRST_STANDARD_MODE;
      3'h3: m = CPL_MODE_AUTO_DCP;
      3'h4: m = CPL_MODE_FORCED_SHORTED;
      3'h5: m = CPL_MODE_FORCED_FIRST_DIVIDER_SCHEME;
      3'h6: m = CPL_MODE_FIRST_STANDARD_MODE;
      default: m = code[0] ? CPL_MODE_CDP : CPL_MODE_SECOND_STANDARD_MODE;
    endcase
    return m;
  endfunction
endpackage

// ### cpl_if.sv
// Interface carrying the charger scheme handshake between top and machine.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface cpl_if;
  logic auto_active;
  logic bc12_attach;
  logic data_line_held;
  logic high_current;
  logic discharge_done;
  logic [1:0] scheme;
  logic discharge_req;
  modport top (output auto_active, bc12_attach, data_line_held, high_current,
    discharge_done, input scheme, discharge_req);
  modport fsm (input auto_active, bc12_attach, data_line_held, high_current,
    discharge_done, output scheme, discharge_req);
endinterface

// ### cpl_qual.sv
// Qualifier: output follows input only after it holds steady for a count.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module cpl_qual
  import cpl_pkg::*;
#(
  parameter logic [CPL_CNT_W-1:0] HOLD_CYC = 32'h00000010
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Clear and level to qualify
  input wire logic clear_i,
  input wire logic level_i,
  output logic qual_o
);
  logic [CPL_CNT_W-1:0] count;

  // A reversal before the count ends restarts the interval
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || level_i == qual_o) begin
      count <= '0;
    end else begin
      count <= count + 32'h00000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      qual_o <= 1'b0;
    end else if (level_i != qual_o && count >= HOLD_CYC - 32'h00000001) begin
      qual_o <= level_i;
    end
  end
endmodule

// ### cpl_dcp_fsm.sv
// Automatic dedicated charger scheme machine.
// Assumes attach and current levels are synchronous; discharge timed by the top.
`timescale 1ns/1ps
module cpl_dcp_fsm
  import cpl_pkg::*;
#(
  parameter logic [CPL_CNT_W-1:0] RETEST_CYC = CPL_RETEST_CYC[CPL_CNT_W-1:0]
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Handshake with the top
  cpl_if.fsm port_if
);
  typedef enum logic [2:0] {
    S_DIV1, S_DIS_TO_BC, S_BC12, S_DIS_TO_DIV2, S_DIV2, S_DIS_TO_DIV1
  } cpl_dcp_state_t;
  cpl_dcp_state_t state, next_state;
  logic [CPL_CNT_W-1:0] dwell;

  always_comb begin
    next_state = state;
    case (state)
      S_DIV1: begin
        if (port_if.bc12_attach) begin
          next_state = S_DIS_TO_BC;
        end else if (port_if.high_current) begin
          next_state = S_DIS_TO_DIV2;
        end
        // Divider-compliant attach draws no extra action here
      end
      S_DIS_TO_BC: if (port_if.discharge_done) next_state = S_BC12;
      S_BC12: if (!port_if.data_line_held) next_state = S_DIV1;
      S_DIS_TO_DIV2: if (port_if.discharge_done) next_state = S_DIV2;
      S_DIV2: begin
        // Give the peripheral time to ramp before judging
        if (dwell >= RETEST_CYC && !port_if.high_current) next_state = S_DIS_TO_DIV1;
      end
      S_DIS_TO_DIV1: if (port_if.discharge_done) next_state = S_DIV1;
      default: next_state = S_DIV1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !port_if.auto_active) begin
      state <= S_DIV1;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state != S_DIV2) begin
      dwell <= '0;
    end else if (dwell < RETEST_CYC) begin
      dwell <= dwell + 32'h00000001;
    end
  end

  always_comb begin
    port_if.discharge_req = (state == S_DIS_TO_BC) || (state == S_DIS_TO_DIV2) ||
      (state == S_DIS_TO_DIV1);
    case (state)
      S_BC12, S_DIS_TO_BC: port_if.scheme = 2'(CPL_SCH_SHORTED);
      S_DIV2, S_DIS_TO_DIV2: port_if.scheme = 2'(CPL_SCH_SECOND_DIVIDER_SCHEME);
      default: port_if.scheme = 2'(CPL_SCH_FIRST_DIVIDER_SCHEME);
    endcase
  end
endmodule

// ### cpl_top.sv
// Charge port controller: load-present indication, charger scheme, faults.
// Assumes analog comparators deliver synchronous levels; Wishbone classic slave.
`timescale 1ns/1ps
module cpl_top
  import cpl_pkg::*;
#(
  parameter logic [CPL_CNT_W-1:0] ASSERT_CYC = CPL_ASSERT_CYC[CPL_CNT_W-1:0],
  parameter logic [CPL_CNT_W-1:0] RELEASE_CYC = CPL_RELEASE_CYC[CPL_CNT_W-1:0],
  parameter logic [CPL_CNT_W-1:0] DISCHARGE_CYC = CPL_DISCHARGE_CYC[CPL_CNT_W-1:0],
  parameter logic [CPL_CNT_W-1:0] RETEST_CYC = CPL_RETEST_CYC[CPL_CNT_W-1:0]
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog comparator levels
  input wire logic load_above_assert_i,
  input wire logic load_below_release_i,
  input wire logic primary_detect_i,
  input wire logic bc12_attach_i,
  input wire logic data_line_held_i,
  input wire logic charge_above_750ma_i,
  input wire logic in_current_limit_i,
  input wire logic temp_above_135_i,
  input wire logic temp_above_155_i,
  input wire logic temp_cooled_135_i,
  input wire logic temp_cooled_155_i,
  input wire logic supply_above_on_i,
  input wire logic supply_below_off_i,
  // Pins and power-stage controls
  output logic load_present_n_o,
  output logic fault_n_o,
  output logic fault_oe_n_o,
  output logic switch_on_o,
  output logic discharge_o,
  output logic use_high_limit_o,
  output logic data_switch_on_o,
  output logic [1:0] scheme_o
);
  logic [31:0] ctrl;
  logic [3:0] mode_code;
  logic [3:0] prev_code;
  cpl_mode_t mode;
  logic detect_mode;
  logic load_up;
  logic load_down;
  logic hold_assert;
  logic hold_release;
  logic load_present;
  logic cl_qual;
  logic shut_135;
  logic shut_155;
  logic input_undervoltage_lockout_ok;
  logic mode_discharge;
  logic [CPL_CNT_W-1:0] dis_count;
  logic dis_active;
  logic fault_now;
  cpl_if port_if();

  assign mode_code = ctrl[CPL_CTRL_MODE_LSB +: 4];
  assign mode = cpl_decode(mode_code);
  assign detect_mode = (mode == CPL_MODE_CDP) ||
    (mode == CPL_MODE_AUTO_DCP && mode_code[0]);

  // Wishbone slave: one wait state, ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CPL_CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
        wb_adr_i == CPL_REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) ctrl[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      case (wb_adr_i)
        CPL_REG_CTRL: wb_dat_o <= ctrl;
        CPL_REG_STATUS: wb_dat_o <= {24'h000000, input_undervoltage_lockout_ok, shut_155, shut_135,
          cl_qual, dis_active, switch_on_o, fault_now, load_present};
        CPL_REG_MODE: wb_dat_o <= {24'h000000, 1'b0, scheme_o, 2'h0, 3'(mode)};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Load detection qualification
  assign load_up = detect_mode && load_above_assert_i;
  assign load_down = load_below_release_i;

  cpl_qual #(.HOLD_CYC(ASSERT_CYC)) u_assert_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!detect_mode),
    .level_i(load_up),
    .qual_o(hold_assert)
  );

  // Release timer runs only while present, so every release waits the full time
  cpl_qual #(.HOLD_CYC(RELEASE_CYC)) u_release_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!detect_mode || !load_present),
    .level_i(load_down),
    .qual_o(hold_release)
  );

  // In CDP a primary detection sets the flag; only a full low-load interval or leaving detection clears it
  always_ff @(posedge clk_i) begin
    if (rst_i || !detect_mode) begin
      load_present <= 1'b0;
    end else if (hold_assert || (mode == CPL_MODE_CDP && primary_detect_i)) begin
      load_present <= 1'b1;
    end else if (hold_release) begin
      load_present <= 1'b0;
    end
  end
  assign load_present_n_o = !load_present;

  // Detection never picks the low limit; only standard and forced modes may
  always_comb begin
    case (mode)
      CPL_MODE_FIRST_STANDARD_MODE, CPL_MODE_FORCED_SHORTED, CPL_MODE_FORCED_FIRST_DIVIDER_SCHEME:
        use_high_limit_o = mode_code[0];
      CPL_MODE_SECOND_STANDARD_MODE: use_high_limit_o = 1'b0;
      default: use_high_limit_o = 1'b1;
    endcase
  end

  // Fault deglitch on current limit
  cpl_qual #(.HOLD_CYC(CPL_FLT_DEGLITCH_CYC[CPL_CNT_W-1:0])) u_cl_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    // Only the onset is deglitched; the pin lets go as soon as the limit ends
    .clear_i(!in_current_limit_i),
    .level_i(in_current_limit_i),
    .qual_o(cl_qual)
  );

  // Thermal shutdowns with cooling hysteresis, cycling while fault persists
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shut_135 <= 1'b0;
    end else if (temp_above_135_i && in_current_limit_i) begin
      shut_135 <= 1'b1;
    end else if (temp_cooled_135_i) begin
      shut_135 <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shut_155 <= 1'b0;
    end else if (temp_above_155_i) begin
      shut_155 <= 1'b1;
    end else if (temp_cooled_155_i) begin
      shut_155 <= 1'b0;
    end
  end

  // Separate on and off thresholds give the lockout its hysteresis
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_undervoltage_lockout_ok <= 1'b0;
    end else if (supply_above_on_i) begin
      input_undervoltage_lockout_ok <= 1'b1;
    end else if (supply_below_off_i) begin
      input_undervoltage_lockout_ok <= 1'b0;
    end
  end

  // Over-temperature is shown without waiting on the deglitch
  assign fault_now = shut_135 || shut_155 || cl_qual;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_oe_n_o <= 1'b1;
    end else begin
      fault_oe_n_o <= !fault_now;
    end
  end
  assign fault_n_o = 1'b0;

  // Mode change discharge; 1110 and 1111 swap silently
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_code <= 4'h0;
    end else begin
      prev_code <= mode_code;
    end
  end
  assign mode_discharge = (prev_code != mode_code) &&
    !(prev_code[3:1] == CPL_CODE_CDP[3:1] && mode_code[3:1] == CPL_CODE_SECOND_STANDARD_MODE[3:1]) &&
    !(cpl_decode(prev_code) == cpl_decode(mode_code));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_count <= '0;
    end else if (mode_discharge || (port_if.discharge_req && !dis_active &&
        !port_if.discharge_done)) begin
      dis_count <= DISCHARGE_CYC;
    end else if (dis_count != '0) begin
      dis_count <= dis_count - 32'h00000001;
    end
  end
  assign dis_active = dis_count != '0;

  // Charger machine inputs
  assign port_if.auto_active = mode == CPL_MODE_AUTO_DCP;
  assign port_if.bc12_attach = bc12_attach_i;
  assign port_if.data_line_held = data_line_held_i;
  assign port_if.high_current = charge_above_750ma_i;
  assign port_if.discharge_done = dis_count == 32'h00000001;

  cpl_dcp_fsm #(.RETEST_CYC(RETEST_CYC)) u_dcp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port_if(port_if)
  );

  // Power stage outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_on_o <= 1'b0;
      discharge_o <= 1'b0;
      data_switch_on_o <= 1'b0;
      scheme_o <= 2'(CPL_SCH_FIRST_DIVIDER_SCHEME);
    end else begin
      // Switch held off while discharging
      switch_on_o <= input_undervoltage_lockout_ok && !shut_135 && !shut_155 && ctrl[CPL_CTRL_SW_EN] &&
        mode != CPL_MODE_DISCHARGE && !dis_active;
      discharge_o <= dis_active || mode == CPL_MODE_DISCHARGE;
      // Data path only in standard and downstream modes
      data_switch_on_o <= ctrl[CPL_CTRL_SW_EN] && !dis_active &&
        (mode == CPL_MODE_FIRST_STANDARD_MODE || mode == CPL_MODE_SECOND_STANDARD_MODE || mode == CPL_MODE_CDP);
      case (mode)
        CPL_MODE_FORCED_SHORTED: scheme_o <= 2'(CPL_SCH_SHORTED);
        CPL_MODE_FORCED_FIRST_DIVIDER_SCHEME: scheme_o <= 2'(CPL_SCH_FIRST_DIVIDER_SCHEME);
        CPL_MODE_AUTO_DCP: scheme_o <= port_if.scheme;
        default: scheme_o <= 2'(CPL_SCH_FIRST_DIVIDER_SCHEME);
      endcase
    end
  end
endmodule

// ### cpl_props.sv
// Checker on the charge port controller pins and bus handshake.
// Assumes it is bound into cpl_top and handed the same assert count.
`timescale 1ns/1ps
module cpl_props
  import cpl_pkg::*;
#(
  parameter logic [CPL_CNT_W-1:0] ASSERT_CYC = 32'h00000014
) (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Comparator levels
  input wire logic load_above_assert_i,
  input wire logic primary_detect_i,
  input wire logic in_current_limit_i,
  input wire logic temp_above_135_i,
  input wire logic temp_above_155_i,
  input wire logic supply_below_off_i,
  // Pins
  input wire logic load_present_n_o,
  input wire logic fault_n_o,
  input wire logic fault_oe_n_o,
  input wire logic switch_on_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Run length of load above threshold, saturating
  logic [CPL_CNT_W-1:0] above_run;
  always_ff @(posedge clk_i) begin
    if (rst_i || !load_above_assert_i) begin
      above_run <= '0;
    end else if (above_run != '1) begin
      above_run <= above_run + 32'h00000001;
    end
  end
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acked");
  property p_od_low;
    !fault_n_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("fault pin value not low");
  property p_hot_fault;
    $rose(temp_above_155_i) |-> ##[1:3] !fault_oe_n_o;
  endproperty
  a_hot_fault: assert property (p_hot_fault) else $error("hot die not flagged");
  property p_off_155;
    temp_above_155_i [*3] |-> !switch_on_o;
  endproperty
  a_off_155: assert property (p_off_155) else $error("switch on above 155");
  property p_off_135;
    (temp_above_135_i && in_current_limit_i) [*3] |-> !switch_on_o;
  endproperty
  a_off_135: assert property (p_off_135) else $error("switch on above 135");
  property p_lockout;
    supply_below_off_i [*3] |-> !switch_on_o;
  endproperty
  a_lockout: assert property (p_lockout) else $error("switch on in lockout");
  // One cycle of limit is inrush, never a fault
  property p_cl_glitch;
    $rose(in_current_limit_i) && fault_oe_n_o && !temp_above_135_i && !temp_above_155_i
      && !$past(temp_above_155_i) |-> ##1 fault_oe_n_o;
  endproperty
  a_cl_glitch: assert property (p_cl_glitch) else $error("limit not deglitched");
  property p_lp_qual;
    $fell(load_present_n_o) && !$past(primary_detect_i) && !$past(primary_detect_i, 2)
      && !$past(primary_detect_i, 3) |-> $past(above_run, 2) >= ASSERT_CYC - 2;
  endproperty
  a_lp_qual: assert property (p_lp_qual) else $error("load present too early");
  c_lp: cover property ($fell(load_present_n_o));
  c_hot: cover property ($fell(switch_on_o) && temp_above_155_i);
  c_cl: cover property (in_current_limit_i && !fault_oe_n_o);
endmodule

bind cpl_top cpl_props #(.ASSERT_CYC(ASSERT_CYC)) u_cpl_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .load_above_assert_i,
  .primary_detect_i, .in_current_limit_i, .temp_above_135_i, .temp_above_155_i,
  .supply_below_off_i, .load_present_n_o, .fault_n_o, .fault_oe_n_o, .switch_on_o
);

// ### cpl_host_model.sv
// Model of the system controller and the attached portable device.
// Assumes the bench sets the draw level and the other port's load-present.
`timescale 1ns/1ps
module cpl_host_model (
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // From the bench
  input wire logic draw_high_i,
  input wire logic peer_present_n_i,
  // Toward the port
  output logic load_above_assert_o,
  output logic load_below_release_o,
  output logic [3:0] mode_code_o
);
  // Load either well above +75 mA or below +25 mA, never between
  always_ff @(posedge clk_i) begin
    load_above_assert_o <= !rst_i && draw_high_i;
    load_below_release_o <= rst_i || !draw_high_i;
  end
  // Only one charging port fits the supply budget
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_code_o <= 4'hf;
    end else begin
      mode_code_o <= peer_present_n_i ? 4'hf : 4'he;
    end
  end
endmodule

// ### cpl_top_bench.sv
// Bench: bus, load detect, port sharing, faults, charger schemes.
// Assumes cpl_top, cpl_props and cpl_host_model are compiled first.
`timescale 1ns/1ps
module cpl_top_bench
  import cpl_pkg::*;
;
  localparam int AS_CYC = 20;
  localparam int RL_CYC = 40;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic pd = 1'b0, bc = 1'b0, held = 1'b0, c750 = 1'b0, cl = 1'b0, t135 = 1'b0;
  logic t155 = 1'b0, c135 = 1'b0, c155 = 1'b0, son = 1'b1, soff = 1'b0;
  logic draw = 1'b0, peer = 1'b1, la, lb, ack, lp_n, f_n, f_oe_n, sw, dis, hl, dsw;
  logic [1:0] sch;
  logic [3:0] pcode;
  int mismatches = 0, check_count = 0;
  always #4 clk_i = ~clk_i;
  cpl_host_model u_cpl_host_model (.clk_i, .rst_i, .draw_high_i(draw),
    .peer_present_n_i(peer), .load_above_assert_o(la), .load_below_release_o(lb),
    .mode_code_o(pcode));
  cpl_top #(.ASSERT_CYC(AS_CYC), .RELEASE_CYC(RL_CYC), .DISCHARGE_CYC(32'h0000000a),
    .RETEST_CYC(32'h0000000f)) u_cpl_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .load_above_assert_i(la), .load_below_release_i(lb),
    .primary_detect_i(pd), .bc12_attach_i(bc), .data_line_held_i(held),
    .charge_above_750ma_i(c750), .in_current_limit_i(cl), .temp_above_135_i(t135),
    .temp_above_155_i(t155), .temp_cooled_135_i(c135), .temp_cooled_155_i(c155),
    .supply_above_on_i(son), .supply_below_off_i(soff), .load_present_n_o(lp_n),
    .fault_n_o(f_n), .fault_oe_n_o(f_oe_n), .switch_on_o(sw), .discharge_o(dis),
    .use_high_limit_o(hl), .data_switch_on_o(dsw), .scheme_o(sch));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      $display("ERROR bus ack expected 1 seen %b", ack);
      end_of_test();
    end
    @(posedge clk_i);
  endtask
  // Kind 0 scheme, 1 switch, 2 discharge
  task automatic wait_for(input int k, input logic [1:0] v);
    logic [1:0] s;
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk_i);
      s = k == 0 ? sch : (k == 1 ? {1'b0, sw} : {1'b0, dis});
      if (s === v) return;
    end
    mismatches++;
    $display("ERROR wait %0d expected %h seen %h", k, v, s);
    end_of_test();
  endtask
  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, CPL_REG_CTRL, 32'h0, q);
    chk("ctrl reset", CPL_CTRL_RST, q);
    chk1("discharge idle", 1'b1, dis);
    bus(1'b0, 8'hfc, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_detect();
    logic [31:0] q;
    bus(1'b1, CPL_REG_CTRL, 32'h1f, q);
    wait_for(1, 2'h1);
    chk1("high limit", 1'b1, hl);
    draw <= 1'b1;
    cyc_n(AS_CYC - 5);
    draw <= 1'b0;
    cyc_n(1);
    draw <= 1'b1;
    cyc_n(AS_CYC);
    chk1("lp restart", 1'b1, lp_n);
    cyc_n(5);
    chk1("lp set", 1'b0, lp_n);
    bus(1'b0, CPL_REG_MODE, 32'h0, q);
    chk("mode", 32'h4, {29'h0, q[2:0]});
    draw <= 1'b0;
    cyc_n(RL_CYC);
    chk1("lp held", 1'b0, lp_n);
    cyc_n(5);
    chk1("lp clear", 1'b1, lp_n);
  endtask
  task automatic t_primary();
    draw <= 1'b1;
    cyc_n(1);
    draw <= 1'b0;
    pd <= 1'b1;
    cyc_n(4);
    chk1("lp primary", 1'b0, lp_n);
    pd <= 1'b0;
    cyc_n(RL_CYC - 8);
    chk1("lp kept", 1'b0, lp_n);
    cyc_n(10);
    chk1("lp gone", 1'b1, lp_n);
  endtask
  task automatic t_share(input logic p, input logic h);
    logic [31:0] q;
    peer <= p;
    cyc_n(3);
    bus(1'b1, CPL_REG_CTRL, {28'h1, pcode}, q);
    cyc_n(2);
    chk1("limit", h, hl);
    chk1("no discharge", 1'b0, dis);
    chk1("switch kept", 1'b1, sw);
    chk1("data path", 1'b1, dsw);
  endtask
  task automatic t_fault();
    cl <= 1'b1;
    cyc_n(900);
    chk1("fault glitch", 1'b1, f_oe_n);
    cyc_n(110);
    chk1("fault limit", 1'b0, f_oe_n);
    t135 <= 1'b1;
    cyc_n(4);
    chk1("off 135", 1'b0, sw);
    cl <= 1'b0;
    t135 <= 1'b0;
    c135 <= 1'b1;
    wait_for(1, 2'h1);
    cyc_n(3);
    chk1("fault gone", 1'b1, f_oe_n);
    c135 <= 1'b0;
    t155 <= 1'b1;
    cyc_n(3);
    chk1("off 155", 1'b0, sw);
    chk1("fault hot", 1'b0, f_oe_n);
    t155 <= 1'b0;
    c155 <= 1'b1;
    wait_for(1, 2'h1);
    c155 <= 1'b0;
  endtask
  task automatic t_lockout();
    son <= 1'b0;
    soff <= 1'b1;
    cyc_n(4);
    chk1("locked", 1'b0, sw);
    soff <= 1'b0;
    cyc_n(20);
    chk1("hysteresis", 1'b0, sw);
    son <= 1'b1;
    wait_for(1, 2'h1);
  endtask
  task automatic t_mode(input logic [31:0] c);
    logic [31:0] q;
    bus(1'b1, CPL_REG_CTRL, c, q);
    cyc_n(3);
    wait_for(1, 2'h1);
  endtask
  task automatic t_auto();
    t_mode(32'h12);
    chk("start", 32'h0, {30'h0, sch});
    chk1("no data", 1'b0, dsw);
    c750 <= 1'b1;
    wait_for(2, 2'h1);
    wait_for(0, 2'h1);
    cyc_n(60);
    chk("div2 kept", 32'h1, {30'h0, sch});
    c750 <= 1'b0;
    wait_for(0, 2'h0);
    wait_for(2, 2'h0);
    bc <= 1'b1;
    held <= 1'b1;
    wait_for(2, 2'h1);
    wait_for(0, 2'h2);
    bc <= 1'b0;
    cyc_n(60);
    chk("shorted kept", 32'h2, {30'h0, sch});
    held <= 1'b0;
    wait_for(0, 2'h0);
    cyc_n(60);
    chk("div1 kept", 32'h0, {30'h0, sch});
  endtask
  task automatic t_forced();
    t_mode(32'h18);
    c750 <= 1'b1;
    cyc_n(60);
    chk("forced short", 32'h2, {30'h0, sch});
    chk1("no data", 1'b0, dsw);
    t_mode(32'h1a);
    cyc_n(60);
    chk("forced div1", 32'h0, {30'h0, sch});
    c750 <= 1'b0;
  endtask
  task automatic t_auto_detect();
    t_mode(32'h17);
    draw <= 1'b1;
    cyc_n(AS_CYC + 5);
    chk1("lp auto", 1'b0, lp_n);
    draw <= 1'b0;
    cyc_n(RL_CYC + 5);
    chk1("lp auto clear", 1'b1, lp_n);
  endtask
  initial begin
    cyc_n(16);
    rst_i <= 1'b0;
    cyc_n(1);
    t_regs();
    t_detect();
    t_primary();
    t_share(1'b0, 1'b0);
    t_share(1'b1, 1'b1);
    t_fault();
    t_lockout();
    t_auto();
    t_forced();
    t_auto_detect();
    end_of_test();
  end
endmodule
